// ===== inc/fmc_pkg.sv
package fmc_pkg;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [4:0] FMC_ADR_CTRL1 = 5'h00;
  localparam logic [4:0] FMC_ADR_CTRL2 = 5'h04;
  localparam logic [4:0] FMC_ADR_CAPT = 5'h08;
  localparam logic [4:0] FMC_ADR_GPER = 5'h0c;
  localparam logic [4:0] FMC_ADR_STAT = 5'h10;
  localparam logic [4:0] FMC_ADR_ISTAT = 5'h14;
  localparam logic [4:0] FMC_ADR_IMASK = 5'h18;

  // ==========================================================
  // Field positions
  localparam int FMC_C1_START = 0;
  localparam int FMC_C1_SRC = 1;
  localparam int FMC_C1_CLEAR = 3;
  localparam int FMC_C2_GSEL = 0;
  localparam int FMC_C2_EDGE = 2;
  localparam int FMC_C2_MODE = 3;
  localparam int FMC_C2_ODIS = 4;
  localparam int FMC_C2_PSEL = 5;
  localparam int FMC_C2_DIV = 7;
  localparam int FMC_C2_SLOW = 8;
  localparam int FMC_GP_LO = 4;
  localparam int FMC_ST_GATE = 0;
  localparam int FMC_ST_OVF = 1;
  localparam int FMC_IRQ_GATE = 0;
  localparam int FMC_IRQ_OVF = 1;

  // ==========================================================
  // Encodings and widths
  localparam logic [1:0] FMC_SRC_EXT = 2'h3;
  localparam logic [1:0] FMC_GS_PIN = 2'h0;
  localparam logic [1:0] FMC_GS_TMR = 2'h1;
  localparam logic [1:0] FMC_GS_INT = 2'h2;
  localparam int FMC_CNT_W = 18;
  localparam logic [17:0] FMC_CNT_MAX = 18'h3ffff;
  localparam int FMC_DIV_W = 16;
  localparam int FMC_FS_BASE = 4;
  localparam logic [4:0] FMC_PER_TOP = 5'h10;

  // Internal gate generator states
  typedef enum logic [1:0] {
    FMC_G_IDLE = 2'b00,
    FMC_G_HIGH = 2'b01,
    FMC_G_LOW = 2'b10
  } fmc_gstate_t;

  // Complete block state
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic start;
    logic [1:0] src_sel;
    logic [1:0] gsel;
    logic edge_both;
    logic edge_mode;
    logic out_dis;
    logic [1:0] psel;
    logic div_sel;
    logic slow;
    logic [3:0] hi_set;
    logic [3:0] lo_set;
    logic [3:0] hi_sh;
    logic [3:0] lo_sh;
    logic [17:0] cnt;
    logic ovf;
    logic [1:0] ist;
    logic [1:0] imask;
    logic irq;
    logic cin_s1;
    logic cin_s2;
    logic gpin_s1;
    logic gpin_s2;
    logic cin_prev;
    logic and_prev;
    logic gate_prev;
    fmc_gstate_t gst;
    logic [4:0] gcnt;
    logic [15:0] div;
    logic [5:0] fsdiv;
    logic pin_out;
    logic pin_oe_n;
  } fmc_state_t;

endpackage : fmc_pkg

// ===== core/fmc_top.sv
module fmc_top #(
  parameter int FC_SHIFT_BASE = 12
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [4:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Measurement pins
  input wire logic COUNT_INPUT_PIN,
  input wire logic EXTERNAL_GATE_PIN,
  // Other timer and low-frequency tick, same clock
  input wire logic OTHER_TIMER_OUTPUT,
  input wire logic FS_TICK,
  // Shared output pin
  output logic SHARED_OUTPUT_PIN,
  output logic SHARED_OUTPUT_PIN_OE_N,
  // Interrupt
  output logic TIMER_INTERRUPT
);
  import fmc_pkg::*;

  // ==========================================================
  // Helpers
  // True on the last cycle of a power-of-two divider period
  function automatic logic tick_f(input logic [15:0] c, input int sh);
    logic [15:0] m;
    m = (16'h0001 << sh) - 16'h0001;
    return (c & m) == m;
  endfunction : tick_f

  // Prescale select 11 behaves as 10
  function automatic int ps_f(input logic [1:0] p);
    return (p == 2'h3) ? 2 : int'(p);
  endfunction : ps_f

  fmc_state_t q;
  fmc_state_t d;
  logic req;
  logic wr;
  logic clr;
  logic gate;
  logic gtick;
  logic en;
  logic cin_fall;
  logic and_now;
  logic gfall;
  logic grise;
  logic inc;
  logic [1:0] ev;

  // ==========================================================
  // Bus and event decode
  always_comb begin
    req = WB_CYC_I && WB_STB_I;
    wr = req && WB_WE_I && q.ack && WB_SEL_I[0];
    clr = wr && WB_ADR_I == FMC_ADR_CTRL1 && WB_DAT_I[FMC_C1_CLEAR];
    // Gate source mux
    case (q.gsel)
      FMC_GS_PIN: gate = q.gpin_s2;
      FMC_GS_TMR: gate = OTHER_TIMER_OUTPUT;
      FMC_GS_INT: gate = (q.gst == FMC_G_HIGH);
      default: gate = 1'b0;
    endcase
    // Gate prescale tick from fast divider or slow tick
    if (q.div_sel || q.slow) begin
      gtick = FS_TICK &&
        tick_f({10'h000, q.fsdiv}, FMC_FS_BASE + ps_f(q.psel));
    end else begin
      gtick = tick_f(q.div, FC_SHIFT_BASE + ps_f(q.psel));
    end
    en = q.start && q.src_sel == FMC_SRC_EXT;
    cin_fall = q.cin_prev && !q.cin_s2;
    and_now = q.cin_s2 && gate;
    gfall = q.gate_prev && !gate;
    grise = !q.gate_prev && gate;
    if (q.edge_mode) begin
      inc = en && ((cin_fall && gate) || gfall);
    end else begin
      inc = en && q.and_prev && !and_now;
    end
    ev = 2'b00;
    ev[FMC_IRQ_GATE] = gfall || (q.edge_both && grise);
    ev[FMC_IRQ_OVF] = inc && q.cnt == FMC_CNT_MAX;
  end

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    // Two-stage synchronisers for pins
    d.cin_s1 = COUNT_INPUT_PIN;
    d.cin_s2 = q.cin_s1;
    d.gpin_s1 = EXTERNAL_GATE_PIN;
    d.gpin_s2 = q.gpin_s1;
    d.cin_prev = q.cin_s2;
    d.and_prev = and_now;
    d.gate_prev = gate;
    d.div = q.div + 16'h0001;
    if (FS_TICK) begin
      d.fsdiv = q.fsdiv + 6'h01;
    end

    // Bus answer one cycle after the request
    d.ack = req && !q.ack;
    d.rdat = 32'h0000_0000;
    if (req && !q.ack && !WB_WE_I) begin
      case (WB_ADR_I)
        FMC_ADR_CTRL1: begin
          d.rdat[FMC_C1_START] = q.start;
          d.rdat[FMC_C1_SRC +: 2] = q.src_sel;
        end
        FMC_ADR_CTRL2: begin
          d.rdat[FMC_C2_GSEL +: 2] = q.gsel;
          d.rdat[FMC_C2_EDGE] = q.edge_both;
          d.rdat[FMC_C2_MODE] = q.edge_mode;
          d.rdat[FMC_C2_ODIS] = q.out_dis;
          d.rdat[FMC_C2_PSEL +: 2] = q.psel;
          d.rdat[FMC_C2_DIV] = q.div_sel;
          d.rdat[FMC_C2_SLOW] = q.slow;
        end
        FMC_ADR_CAPT: d.rdat[FMC_CNT_W-1:0] = q.cnt;
        FMC_ADR_GPER: d.rdat[7:0] = {q.lo_set, q.hi_set};
        FMC_ADR_STAT: begin
          d.rdat[FMC_ST_GATE] = q.gate_prev;
          d.rdat[FMC_ST_OVF] = q.ovf;
        end
        FMC_ADR_ISTAT: d.rdat[1:0] = q.ist;
        FMC_ADR_IMASK: d.rdat[1:0] = q.imask;
        default: d.rdat = 32'h0000_0000;
      endcase
    end

    // Register writes need the low byte lane; the CTRL2 slow bit also needs lane 1
    if (wr) begin
      case (WB_ADR_I)
        FMC_ADR_CTRL1: begin
          d.start = WB_DAT_I[FMC_C1_START];
          d.src_sel = WB_DAT_I[FMC_C1_SRC +: 2];
        end
        FMC_ADR_CTRL2: begin
          d.gsel = WB_DAT_I[FMC_C2_GSEL +: 2];
          d.edge_both = WB_DAT_I[FMC_C2_EDGE];
          d.edge_mode = WB_DAT_I[FMC_C2_MODE];
          d.out_dis = WB_DAT_I[FMC_C2_ODIS];
          d.psel = WB_DAT_I[FMC_C2_PSEL +: 2];
          d.div_sel = WB_DAT_I[FMC_C2_DIV];
          d.slow = WB_SEL_I[1] ? WB_DAT_I[FMC_C2_SLOW] : q.slow;
        end
        FMC_ADR_GPER: begin
          d.hi_set = WB_DAT_I[3:0];
          d.lo_set = WB_DAT_I[FMC_GP_LO +: 4];
        end
        FMC_ADR_IMASK: d.imask = WB_DAT_I[1:0];
        default: d.imask = q.imask;
      endcase
    end

    // Counter, held while gate stays low after its falling cycle, resumed when not cleared
    if (clr) begin
      d.cnt = '0;
    end else if (inc) begin
      d.cnt = q.cnt + 18'h00001;
    end
    // Overflow flag, a wrap in the clearing cycle still sets it
    if (ev[FMC_IRQ_OVF]) begin
      d.ovf = 1'b1;
    end else if (clr) begin
      d.ovf = 1'b0;
    end

    // Sticky interrupt status, write one to clear, set wins
    if (wr && WB_ADR_I == FMC_ADR_ISTAT) begin
      d.ist = q.ist & ~WB_DAT_I[1:0];
    end
    d.ist = d.ist | ev;
    d.irq = |(q.ist & q.imask);

    // Internal gate generator
    if (!(q.start && q.gsel == FMC_GS_INT)) begin
      d.gst = FMC_G_IDLE;
      d.gcnt = 5'h00;
    end else begin
      case (q.gst)
        FMC_G_IDLE: begin
          // First high waits for a divider tick
          if (gtick) begin
            d.gst = FMC_G_HIGH;
            d.hi_sh = q.hi_set;
            d.lo_sh = q.lo_set;
            d.gcnt = FMC_PER_TOP - {1'b0, q.hi_set};
          end
        end
        FMC_G_HIGH: begin
          if (gtick) begin
            if (q.gcnt == 5'h01) begin
              // New settings are taken on entry to the low period
              d.gst = FMC_G_LOW;
              d.hi_sh = q.hi_set;
              d.lo_sh = q.lo_set;
              d.gcnt = FMC_PER_TOP - {1'b0, q.lo_set};
            end else begin
              d.gcnt = q.gcnt - 5'h01;
            end
          end
        end
        FMC_G_LOW: begin
          if (gtick) begin
            if (q.gcnt == 5'h01) begin
              d.gst = FMC_G_HIGH;
              d.gcnt = FMC_PER_TOP - {1'b0, q.hi_sh};
            end else begin
              d.gcnt = q.gcnt - 5'h01;
            end
          end
        end
        default: d.gst = FMC_G_IDLE;
      endcase
    end

    // Shared pin carries the other timer output when enabled
    d.pin_out = OTHER_TIMER_OUTPUT;
    d.pin_oe_n = !(q.gsel == FMC_GS_TMR && !q.out_dis);
  end

  // ==========================================================
  // State register
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      q <= '0;
      q.pin_oe_n <= 1'b1;
      q.gst <= FMC_G_IDLE;
    end else begin
      q <= d;
    end
  end

  // Outputs
  always_comb begin
    WB_DAT_O = q.rdat;
    WB_ACK_O = q.ack;
    SHARED_OUTPUT_PIN = q.pin_out;
    SHARED_OUTPUT_PIN_OE_N = q.pin_oe_n;
    TIMER_INTERRUPT = q.irq;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  ack_single_a: assert property (q.ack |=> !q.ack)
    else $error("ack held longer than one cycle");

  clear_count_a: assert property (clr |=>
    q.cnt == 18'h00000 && !q.ovf || q.ovf && $past(ev[FMC_IRQ_OVF]))
    else $error("clear did not zero the counter");

  count_hold_a: assert property (!gate && !q.gate_prev && !clr
    |=> q.cnt == $past(q.cnt))
    else $error("counter moved while gate low");

  wrap_flag_a: assert property (q.cnt == FMC_CNT_MAX && inc && !clr
    |=> q.cnt == 18'h00000 && q.ovf)
    else $error("wrap did not set overflow");

  ovf_keep_a: assert property (q.ovf && !clr |=> q.ovf)
    else $error("overflow flag lost without clear");

  fall_irq_a: assert property (en && q.gate_prev && !gate
    |=> q.ist[FMC_IRQ_GATE] ##1 q.irq == q.imask[FMC_IRQ_GATE])
    else $error("gate fall did not raise event");

  mode_one_a: assert property (q.edge_mode && en && gfall && !clr
    |=> q.cnt == $past(q.cnt) + 18'h00001)
    else $error("gate fall did not add one");

  pin_route_a: assert property (q.gsel == FMC_GS_TMR && !q.out_dis
    ##1 q.gsel == FMC_GS_TMR && !q.out_dis |-> !SHARED_OUTPUT_PIN_OE_N)
    else $error("shared pin not driven");

  gate_flag_a: assert property (q.gsel == FMC_GS_PIN
    |=> q.gate_prev == $past(q.gpin_s2))
    else $error("gate flag does not follow pin");

endmodule : fmc_top

// ===== verification/fmc_pulse_source.sv
module fmc_pulse_source (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Burst request
  input wire logic go,
  input wire logic [7:0] n,
  input wire logic hold_hi,
  // Measured signal
  output logic pin,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q;
  logic [1:0] ph_q;
  // ==========================================================
  // Burst of n four-cycle pulses, then rest at the asked level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left_q <= 8'h00;
      ph_q <= 2'h0;
      pin <= 1'b0;
    end else if (go) begin
      left_q <= n;
      ph_q <= 2'h0;
    end else if (left_q != 8'h00) begin
      ph_q <= ph_q + 2'h1;
      pin <= (ph_q < 2'h2); // One falling edge per pulse
      if (ph_q == 2'h3) begin
        left_q <= left_q - 8'h01;
      end
    end else begin
      pin <= hold_hi;
    end
  end
  // Burst finished
  assign done = (left_q == 8'h00);
endmodule : fmc_pulse_source

// ===== verification/fmc_top_test.sv
module fmc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fmc_pkg::*;
  // ==========================================================
  // Stimulus and observation signals
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic gate = 0, oth = 0, go = 0, hi = 0, done;
  logic fs = 0;
  logic [4:0] adr = 5'h00;
  logic [7:0] n = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic ack, shp, shp_oe_n, irq, cin;
  int failures = 0, cmp_count = 0, cyc_n = 0;
  // Clock of 20 ns
  always #10 clk = ~clk;
  fmc_top #(.FC_SHIFT_BASE(2)) dut (.SYS_CLK(clk), .RST_N(rst_n),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .COUNT_INPUT_PIN(cin), .EXTERNAL_GATE_PIN(gate),
    .OTHER_TIMER_OUTPUT(oth), .FS_TICK(fs), .SHARED_OUTPUT_PIN(shp),
    .SHARED_OUTPUT_PIN_OE_N(shp_oe_n), .TIMER_INTERRUPT(irq));
  fmc_pulse_source src (.clk(clk), .rst_n(rst_n), .go(go), .n(n),
    .hold_hi(hi), .pin(cin), .done(done));
  // ==========================================================
  // Shared tasks
  task automatic conclude;
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Wait ends when ack is sampled high, or the hang guard ends the run
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask : wb
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    wb(1'b1, a, d, rd);
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, rd);
    check(rd, e);
  endtask : rc
  task automatic setg(input logic v);
    @(posedge clk);
    gate <= v;
    tick(4);
  endtask : setg
  task automatic pulses(input logic [7:0] c);
    @(posedge clk);
    n <= c;
    go <= 1;
    @(posedge clk);
    go <= 0;
    tick(1);
    while (done !== 1'b1) begin
      @(posedge clk);
    end
    tick(5);
  endtask : pulses
  // A run of len cycles seen by reads three cycles apart
  function automatic logic near3(input int runs, input int len);
    return runs * 3 > len - 3 && runs * 3 < len + 3;
  endfunction : near3
  // Reads in one high and the following low gate period
  task automatic runs(output int r, output int z);
    r = 1;
    z = 1;
    do begin
      wb(1'b0, FMC_ADR_STAT, 32'h0, rd);
    end while (rd[0] !== 1'b0);
    do begin
      wb(1'b0, FMC_ADR_STAT, 32'h0, rd);
    end while (rd[0] !== 1'b1);
    wb(1'b0, FMC_ADR_STAT, 32'h0, rd);
    while (rd[0] === 1'b1) begin
      r++;
      wb(1'b0, FMC_ADR_STAT, 32'h0, rd);
    end
    wb(1'b0, FMC_ADR_STAT, 32'h0, rd);
    while (rd[0] === 1'b0) begin
      z++;
      wb(1'b0, FMC_ADR_STAT, 32'h0, rd);
    end
  endtask : runs
  // ==========================================================
  // Scenarios
  task automatic t_pin;
    rc(5'h1c, 32'h0);
    rc(FMC_ADR_STAT, 32'h0);
    wr(FMC_ADR_IMASK, 32'h1);
    wr(FMC_ADR_CTRL1, 32'h7);
    setg(1);
    rc(FMC_ADR_STAT, 32'h1);
    rc(FMC_ADR_ISTAT, 32'h0);
    pulses(8'd5);
    setg(0);
    rc(FMC_ADR_CAPT, 32'd5);
    rc(FMC_ADR_ISTAT, 32'h1);
    check({31'h0, irq}, 32'h1);
    setg(1);
    pulses(8'd3);
    setg(0);
    rc(FMC_ADR_CAPT, 32'd8);
    wr(FMC_ADR_IMASK, 32'h0);
    tick(2);
    check({31'h0, irq}, 32'h0);
    wr(FMC_ADR_ISTAT, 32'h1);
    rc(FMC_ADR_ISTAT, 32'h0);
    wr(FMC_ADR_CTRL1, 32'hf);
    rc(FMC_ADR_CAPT, 32'h0);
  endtask : t_pin
  task automatic t_edges;
    hi <= 1;
    setg(1);
    setg(0);
    hi <= 0;
    rc(FMC_ADR_CAPT, 32'h1);
    wr(FMC_ADR_CTRL1, 32'hf);
    wr(FMC_ADR_ISTAT, 32'h1);
    wr(FMC_ADR_CTRL2, 32'hc);
    setg(1);
    rc(FMC_ADR_ISTAT, 32'h1);
    setg(0);
    rc(FMC_ADR_CAPT, 32'h1);
    wr(FMC_ADR_CTRL1, 32'hf);
  endtask : t_edges
  task automatic t_share;
    wr(FMC_ADR_CTRL2, 32'h1);
    oth <= 1;
    tick(3);
    check({31'h0, shp_oe_n}, 32'h0);
    check({31'h0, shp}, 32'h1);
    oth <= 0;
    tick(3);
    check({31'h0, shp}, 32'h0);
    wr(FMC_ADR_CTRL2, 32'h11);
    tick(3);
    check({31'h0, shp_oe_n}, 32'h1);
  endtask : t_share
  task automatic t_internal;
    int hits;
    int hr;
    int lr;
    hits = 0;
    wr(FMC_ADR_GPER, 32'h4c);
    wr(FMC_ADR_CTRL2, 32'h2);
    repeat (100) begin
      wb(1'b0, FMC_ADR_STAT, 32'h0, rd);
      hits += int'(rd[0]);
    end
    check({31'h0, hits > 15 && hits < 35}, 32'h1);
    // Tick of 2^(2+0) cycles: high (16-12)*4, low (16-4)*4
    runs(hr, lr);
    check({31'h0, near3(hr, 16)}, 32'h1);
    check({31'h0, near3(lr, 48)}, 32'h1);
  endtask : t_internal
  // Divider stage one with a low-frequency tick on every cycle
  task automatic t_slow;
    int hr;
    int lr;
    fs <= 1;
    wr(FMC_ADR_CTRL2, 32'h0);
    wr(FMC_ADR_GPER, 32'hce);
    wr(FMC_ADR_CTRL2, 32'h82);
    // Tick of 2^4 cycles: high (16-14)*16, low (16-12)*16
    runs(hr, lr);
    check({31'h0, near3(hr, 32)}, 32'h1);
    check({31'h0, near3(lr, 64)}, 32'h1);
  endtask : t_slow
  // ==========================================================
  // Hang guard
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      failures++;
      $display("BAD %0t timeout", $time);
      conclude();
    end
  end
  // Main sequence
  initial begin
    tick(10);
    rst_n <= 1;
    tick(2);
    t_pin();
    t_edges();
    t_share();
    t_internal();
    t_slow();
    conclude();
  end
endmodule : fmc_top_test
